// ===== design/aigc_top.v
// Functional notes
// - Power-down bit stops clock recovery; only hardware reset restores it.
// - HEC algorithm bit: 0 selects ITU-T, 1 selects ATM Forum.
// - HEC mode 0 discards bad-HEC cells; 1 defers to port discard bit on cell-mode ports only.
// - Software reset bit restores registers 0008 to 0012 and 0040, itself included.
// - Separate enables gate cell tx, cell rx, recovery interface, overflow counter.
// - Four-bit dummy RTS is sent in first two SRTS periods.
// - Two-bit select picks one of four byte patterns; pattern registers reset FFFF.
// - Pointer parity off sends bit 7 zero; on sends even parity.
// - Parity test bit inverts expected parity of RAM and cell bus checkers.
// - Destructive read clears OAM counters after read, only while OAM active.
// - OAM inactive stops monitoring and gives processor full external RAM.
// - OAM active shares RAM; interrupt queue reads return the first entry.
// - Six-bit OAM counter enables apply to cell-mode ports only.
// - Sixteen-bit OAM counter enables apply to adaptation-mode ports only.
// - Delineation register holds two nibbles and HEC coset; resets 7655.
// - Rx idle detection compares header nibbles under mask; resets 0101.
// - Tx idle cells carry programmed nibbles, other bits zero; resets 016A.
// - Transparency bits per loop: loop and forward, else only loop.
// - Adaptation ports loop all VCIs unless filter bit; then match five bits.
// - Cell-mode ports in upstream loop loop every cell regardless of VCI.
// - Partial cells are padded with programmable fill octet, reset zero.
// - Port mode bit: 0 adaptation circuit emulation, 1 cell PHY.
// - Port discard bit 1 keeps bad-HEC cells and flags UDF MSB.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`include "aigc_defs.vh"
module aigc_top #(
    parameter PORTS = 8
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Processor port
    input wire [`AIGC_ADDR_W-1:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    // Header, VCI and SDT pointer of the cell under inspection
    input wire [7:0] rx_hdr_oct1,
    input wire [7:0] rx_hdr_oct4,
    input wire [4:0] cell_vci_low,
    input wire [6:0] sdt_pointer,
    // Device controls
    output reg recovery_run,
    output reg hec_forum,
    output reg cellbus_tx_enable,
    output reg cellbus_rx_enable,
    output reg recovery_if_enable,
    output reg ovf_count_enable,
    output reg [3:0] dummy_rts,
    output reg [7:0] emergency_byte,
    output reg parity_expect_inverted,
    output reg [7:0] sdt_pointer_out,
    output reg timer_group1_enable,
    output reg oam_monitor_run,
    output reg oam_dest_read,
    output reg cpu_ram_exclusive,
    output reg irq_queue_head_only,
    output reg [3:0] delin_alpha,
    output reg [3:0] delin_delta,
    output reg [7:0] hec_coset,
    output reg rx_idle_match,
    output reg [7:0] tx_idle_oct1,
    output reg [7:0] tx_idle_oct4,
    output reg [7:0] tx_idle_payload,
    output reg serial_transparent,
    output reg down_transparent,
    output reg vci_loop_accept,
    output reg [7:0] fill_octet,
    // Per-port derived controls
    output reg [PORTS-1:0] oam_cnt_en,
    output reg [PORTS-1:0] hec_discard,
    output reg [PORTS-1:0] udf_hec_flag,
    output reg [PORTS-1:0] up_transparent,
    output reg [PORTS-1:0] up_filter_en
);

////////////////////////////////////////////////////////////////////////////////

    reg [15:0] global_config_r;
    reg [15:0] oam_control_r;
    reg [15:0] oam_cnt_cell_r;
    reg [15:0] oam_cnt_adapt_r;
    reg [15:0] patterns_hi_r;
    reg [15:0] patterns_lo_r;
    reg [15:0] cell_delin_r;
    reg [15:0] rx_idle_r;
    reg [15:0] tx_idle_r;
    reg [15:0] loopback_r;
    reg [15:0] cell_fill_r;
    reg [15:0] port_mode_r;
    reg pwrdn_latch_r;
    reg [15:0] rdata_nxt;

    wire soft_reset_bit;
    wire [PORTS-1:0] lane_oam;
    wire [PORTS-1:0] lane_disc;
    wire [PORTS-1:0] lane_udf;
    wire [PORTS-1:0] lane_upt;
    wire [PORTS-1:0] lane_flt;
    wire [7:0] emg_sel;
    wire [7:0] hdr_diff;

    // Each wrapped register is a write with the matching index.
    function hit;
        input [`AIGC_ADDR_W-1:0] a;
        input [`AIGC_ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // Even parity over seven bits places the parity in bit 7.
    function [7:0] with_parity;
        input [6:0] v;
        input en;
        begin
            with_parity = {en & (^v), v};
        end
    endfunction

    assign soft_reset_bit = global_config_r[`AIGC_GC_SWRST];

////////////////////////////////////////////////////////////////////////////////
// Register file. The software reset occupies one cycle after the write and
// then clears itself together with every other bank register.

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            global_config_r <= `AIGC_RST_ZERO;
            oam_control_r <= `AIGC_RST_ZERO;
            oam_cnt_cell_r <= `AIGC_RST_ZERO;
            oam_cnt_adapt_r <= `AIGC_RST_ZERO;
            patterns_hi_r <= `AIGC_RST_PATTERNS;
            patterns_lo_r <= `AIGC_RST_PATTERNS;
            cell_delin_r <= `AIGC_RST_CELL_DELIN;
            rx_idle_r <= `AIGC_RST_RX_IDLE;
            tx_idle_r <= `AIGC_RST_TX_IDLE;
            loopback_r <= `AIGC_RST_ZERO;
            cell_fill_r <= `AIGC_RST_ZERO;
            port_mode_r <= `AIGC_RST_ZERO;
        end else if (soft_reset_bit) begin
            global_config_r <= `AIGC_RST_ZERO;
            oam_control_r <= `AIGC_RST_ZERO;
            oam_cnt_cell_r <= `AIGC_RST_ZERO;
            oam_cnt_adapt_r <= `AIGC_RST_ZERO;
            patterns_hi_r <= `AIGC_RST_PATTERNS;
            patterns_lo_r <= `AIGC_RST_PATTERNS;
            cell_delin_r <= `AIGC_RST_CELL_DELIN;
            rx_idle_r <= `AIGC_RST_RX_IDLE;
            tx_idle_r <= `AIGC_RST_TX_IDLE;
            loopback_r <= `AIGC_RST_ZERO;
            cell_fill_r <= `AIGC_RST_ZERO;
            port_mode_r <= `AIGC_RST_ZERO;
        end else if (wr) begin
            if (hit(addr, `AIGC_OFS_GLOBAL_CONFIG))
                global_config_r <= wdata;
            if (hit(addr, `AIGC_OFS_OAM_CONTROL)) begin
                oam_control_r <= wdata & `AIGC_MSK_OAM_CONTROL;
                // Destructive read is refused unless monitoring is switched on too.
                oam_control_r[`AIGC_OC_DEST] <= wdata[`AIGC_OC_DEST] &
                    wdata[`AIGC_OC_ACT];
            end
            if (hit(addr, `AIGC_OFS_OAM_CNT_CELL))
                oam_cnt_cell_r <= wdata & `AIGC_MSK_OAM_CNT_CELL;
            if (hit(addr, `AIGC_OFS_OAM_CNT_ADAPT))
                oam_cnt_adapt_r <= wdata;
            if (hit(addr, `AIGC_OFS_PATTERNS_HI))
                patterns_hi_r <= wdata;
            if (hit(addr, `AIGC_OFS_PATTERNS_LO))
                patterns_lo_r <= wdata;
            if (hit(addr, `AIGC_OFS_CELL_DELIN))
                cell_delin_r <= wdata;
            if (hit(addr, `AIGC_OFS_RX_IDLE))
                rx_idle_r <= wdata;
            if (hit(addr, `AIGC_OFS_TX_IDLE))
                tx_idle_r <= wdata;
            if (hit(addr, `AIGC_OFS_LOOPBACK))
                loopback_r <= wdata & `AIGC_MSK_LOOPBACK;
            if (hit(addr, `AIGC_OFS_CELL_FILL))
                cell_fill_r <= wdata & `AIGC_MSK_BYTE;
            if (hit(addr, `AIGC_OFS_PORT_MODE))
                port_mode_r <= wdata;
        end
    end

    // Power-down is sticky: neither clearing the bit nor a software reset
    // revives clock recovery, because the bank reset cannot reach this latch.
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            pwrdn_latch_r <= 1'b0;
        else if (global_config_r[`AIGC_GC_PWRDN])
            pwrdn_latch_r <= 1'b1;
    end

////////////////////////////////////////////////////////////////////////////////
// Read port. Unmapped addresses read as zero.

    always @* begin
        rdata_nxt = 16'h0000;
        case (addr)
            `AIGC_OFS_GLOBAL_CONFIG: rdata_nxt = global_config_r;
            `AIGC_OFS_OAM_CONTROL: rdata_nxt = oam_control_r;
            `AIGC_OFS_OAM_CNT_CELL: rdata_nxt = oam_cnt_cell_r;
            `AIGC_OFS_OAM_CNT_ADAPT: rdata_nxt = oam_cnt_adapt_r;
            `AIGC_OFS_PATTERNS_HI: rdata_nxt = patterns_hi_r;
            `AIGC_OFS_PATTERNS_LO: rdata_nxt = patterns_lo_r;
            `AIGC_OFS_CELL_DELIN: rdata_nxt = cell_delin_r;
            `AIGC_OFS_RX_IDLE: rdata_nxt = rx_idle_r;
            `AIGC_OFS_TX_IDLE: rdata_nxt = tx_idle_r;
            `AIGC_OFS_LOOPBACK: rdata_nxt = loopback_r;
            `AIGC_OFS_CELL_FILL: rdata_nxt = cell_fill_r;
            `AIGC_OFS_PORT_MODE: rdata_nxt = port_mode_r;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            rdata <= 16'h0000;
        else if (rd)
            rdata <= rdata_nxt;
        else
            rdata <= 16'h0000;
    end

////////////////////////////////////////////////////////////////////////////////
// Per-port decode.

    aigc_lane_cfg #(
        .PORTS(PORTS)
    ) u_lane (
        .oam_cnt_cell(oam_cnt_cell_r),
        .oam_cnt_adapt(oam_cnt_adapt_r),
        .loopback(loopback_r),
        .hec_mode(global_config_r[`AIGC_GC_HEC_MODE]),
        .port_cell_mode(port_mode_r[PORTS-1:0]),
        .port_cell_disc(port_mode_r[PORTS-1:0] & ~port_mode_r[15:16-PORTS]),
        .port_up_loop(port_mode_r[15:16-PORTS]),
        .oam_cnt_en(lane_oam),
        .hec_discard(lane_disc),
        .udf_hec_flag(lane_udf),
        .up_transparent(lane_upt),
        .up_filter_en(lane_flt)
    );

    assign emg_sel = global_config_r[`AIGC_GC_EMG_HI:`AIGC_GC_EMG_LO] == 2'b00 ?
        patterns_lo_r[7:0] : global_config_r[`AIGC_GC_EMG_HI:`AIGC_GC_EMG_LO] == 2'b01 ?
        patterns_lo_r[15:8] : global_config_r[`AIGC_GC_EMG_HI:`AIGC_GC_EMG_LO] == 2'b10 ?
        patterns_hi_r[7:0] : patterns_hi_r[15:8];

    // Header bits: octet 1 upper nibble and octet 4 lower nibble are compared;
    // all other bits must be zero, which the match logic checks on the received header.
    assign hdr_diff = {rx_hdr_oct1[7:4], rx_hdr_oct4[3:0]} ^ rx_idle_r[15:8];

////////////////////////////////////////////////////////////////////////////////
// Registered outputs.

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            recovery_run <= 1'b0;
            hec_forum <= 1'b0;
            cellbus_tx_enable <= 1'b0;
            cellbus_rx_enable <= 1'b0;
            recovery_if_enable <= 1'b0;
            ovf_count_enable <= 1'b0;
            dummy_rts <= 4'h0;
            emergency_byte <= 8'hff;
            parity_expect_inverted <= 1'b0;
            sdt_pointer_out <= 8'h00;
            timer_group1_enable <= 1'b0;
            oam_monitor_run <= 1'b0;
            oam_dest_read <= 1'b0;
            cpu_ram_exclusive <= 1'b1;
            irq_queue_head_only <= 1'b0;
            delin_alpha <= 4'h7;
            delin_delta <= 4'h6;
            hec_coset <= 8'h55;
            rx_idle_match <= 1'b0;
            tx_idle_oct1 <= 8'h00;
            tx_idle_oct4 <= 8'h01;
            tx_idle_payload <= 8'h6a;
            serial_transparent <= 1'b0;
            down_transparent <= 1'b0;
            vci_loop_accept <= 1'b1;
            fill_octet <= 8'h00;
            oam_cnt_en <= {PORTS{1'b0}};
            hec_discard <= {PORTS{1'b1}};
            udf_hec_flag <= {PORTS{1'b0}};
            up_transparent <= {PORTS{1'b0}};
            up_filter_en <= {PORTS{1'b0}};
        end else begin
            recovery_run <= ~pwrdn_latch_r & ~global_config_r[`AIGC_GC_PWRDN];
            hec_forum <= global_config_r[`AIGC_GC_HEC_ALG];
            cellbus_tx_enable <= global_config_r[`AIGC_GC_TX_EN];
            cellbus_rx_enable <= global_config_r[`AIGC_GC_RX_EN];
            recovery_if_enable <= global_config_r[`AIGC_GC_CRV_EN];
            ovf_count_enable <= global_config_r[`AIGC_GC_OVF_EN];
            dummy_rts <= global_config_r[`AIGC_GC_RTS_HI:`AIGC_GC_RTS_LO];
            emergency_byte <= emg_sel;
            parity_expect_inverted <= global_config_r[`AIGC_GC_INV_PAR];
            sdt_pointer_out <= with_parity(sdt_pointer,
                global_config_r[`AIGC_GC_PTR_PAR]);
            timer_group1_enable <= oam_control_r[`AIGC_OC_TIMER1];
            oam_monitor_run <= oam_control_r[`AIGC_OC_ACT];
            oam_dest_read <= oam_control_r[`AIGC_OC_DEST] &
                oam_control_r[`AIGC_OC_ACT];
            cpu_ram_exclusive <= ~oam_control_r[`AIGC_OC_ACT];
            irq_queue_head_only <= oam_control_r[`AIGC_OC_ACT];
            delin_alpha <= cell_delin_r[15:12];
            delin_delta <= cell_delin_r[11:8];
            hec_coset <= cell_delin_r[7:0];
            rx_idle_match <= ((hdr_diff & ~rx_idle_r[7:0]) == 8'h00) &
                (rx_hdr_oct1[3:0] == 4'h0) & (rx_hdr_oct4[7:4] == 4'h0);
            tx_idle_oct1 <= {tx_idle_r[15:12], 4'h0};
            tx_idle_oct4 <= {4'h0, tx_idle_r[11:8]};
            tx_idle_payload <= tx_idle_r[7:0];
            serial_transparent <= loopback_r[`AIGC_LB_SERIAL];
            down_transparent <= loopback_r[`AIGC_LB_DOWN];
            vci_loop_accept <= ~loopback_r[`AIGC_LB_FILT] |
                (cell_vci_low == loopback_r[4:0]);
            fill_octet <= cell_fill_r[7:0];
            oam_cnt_en <= lane_oam;
            hec_discard <= lane_disc;
            udf_hec_flag <= lane_udf;
            up_transparent <= lane_upt;
            up_filter_en <= lane_flt;
        end
    end

endmodule

// ===== design/aigc_defs.vh
`ifndef AIGC_DEFS_VH
`define AIGC_DEFS_VH
// Register indices (word addresses on the processor port).
`define AIGC_ADDR_W 18
`define AIGC_OFS_GLOBAL_CONFIG 18'h0_0008
`define AIGC_OFS_OAM_CONTROL 18'h0_0009
`define AIGC_OFS_OAM_CNT_CELL 18'h0_000a
`define AIGC_OFS_OAM_CNT_ADAPT 18'h0_000b
`define AIGC_OFS_PATTERNS_HI 18'h0_000c
`define AIGC_OFS_PATTERNS_LO 18'h0_000d
`define AIGC_OFS_CELL_DELIN 18'h0_000e
`define AIGC_OFS_RX_IDLE 18'h0_000f
`define AIGC_OFS_TX_IDLE 18'h0_0010
`define AIGC_OFS_LOOPBACK 18'h0_0011
`define AIGC_OFS_CELL_FILL 18'h0_0012
`define AIGC_OFS_PORT_MODE 18'h0_0040
`define AIGC_SWRST_LAST 18'h0_0031
// Reset values.
`define AIGC_RST_ZERO 16'h0000
`define AIGC_RST_PATTERNS 16'hffff
`define AIGC_RST_CELL_DELIN 16'h7655
`define AIGC_RST_RX_IDLE 16'h0101
`define AIGC_RST_TX_IDLE 16'h016a
// Writable masks.
`define AIGC_MSK_OAM_CONTROL 16'h0007
`define AIGC_MSK_OAM_CNT_CELL 16'h003f
`define AIGC_MSK_LOOPBACK 16'h01ff
`define AIGC_MSK_BYTE 16'h00ff
// global_config fields.
`define AIGC_GC_PWRDN 15
`define AIGC_GC_HEC_ALG 14
`define AIGC_GC_HEC_MODE 13
`define AIGC_GC_SWRST 12
`define AIGC_GC_TX_EN 11
`define AIGC_GC_RX_EN 10
`define AIGC_GC_CRV_EN 9
`define AIGC_GC_RTS_HI 8
`define AIGC_GC_RTS_LO 5
`define AIGC_GC_EMG_HI 4
`define AIGC_GC_EMG_LO 3
`define AIGC_GC_OVF_EN 2
`define AIGC_GC_PTR_PAR 1
`define AIGC_GC_INV_PAR 0
// oam_control fields.
`define AIGC_OC_TIMER1 2
`define AIGC_OC_DEST 1
`define AIGC_OC_ACT 0
// loopback_control fields.
`define AIGC_LB_SERIAL 8
`define AIGC_LB_UP 7
`define AIGC_LB_DOWN 6
`define AIGC_LB_FILT 5
`endif

// ===== design/aigc_lane_cfg.v
`timescale 1ns/1ns
`include "aigc_defs.vh"
module aigc_lane_cfg #(
    parameter PORTS = 8
) (
    // Shared settings
    input wire [15:0] oam_cnt_cell,
    input wire [15:0] oam_cnt_adapt,
    input wire [15:0] loopback,
    input wire hec_mode,
    // Per-port mode
    input wire [PORTS-1:0] port_cell_mode,
    input wire [PORTS-1:0] port_cell_disc,
    input wire [PORTS-1:0] port_up_loop,
    // Derived per-port controls
    output reg [PORTS-1:0] oam_cnt_en,
    output reg [PORTS-1:0] hec_discard,
    output reg [PORTS-1:0] udf_hec_flag,
    output reg [PORTS-1:0] up_transparent,
    output reg [PORTS-1:0] up_filter_en
);
    integer i;
    always @* begin
        for (i = 0; i < PORTS; i = i + 1) begin
            // Cell-mode ports use the 6-bit field, adaptation ports the 16-bit one.
            if (port_cell_mode[i]) begin
                oam_cnt_en[i] = (i < 6) ? oam_cnt_cell[i % 6] : 1'b0;
                up_transparent[i] = 1'b0;
                up_filter_en[i] = 1'b0;
            end else begin
                oam_cnt_en[i] = oam_cnt_adapt[i % 16];
                up_transparent[i] = loopback[`AIGC_LB_UP];
                up_filter_en[i] = port_up_loop[i] & loopback[`AIGC_LB_FILT];
            end
            // Discard is forced unless the global mode defers to the port setting and the port is in cell mode.
            hec_discard[i] = ~hec_mode | ~port_cell_mode[i] | port_cell_disc[i];
            udf_hec_flag[i] = ~hec_discard[i];
        end
    end
endmodule

// ===== verif/aigc_top_props.sv
`timescale 1ns/1ns
`include "aigc_defs.vh"
module aigc_top_props (
    // Clock, reset and processor port
    input wire ref_clk,
    input wire rst,
    input wire [`AIGC_ADDR_W-1:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    input wire [15:0] rdata,
    // Watched controls
    input wire [6:0] sdt_pointer,
    input wire recovery_run,
    input wire hec_forum,
    input wire cellbus_tx_enable,
    input wire [3:0] dummy_rts,
    input wire [7:0] emergency_byte,
    input wire [7:0] sdt_pointer_out,
    input wire [7:0] fill_octet
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    chk_rdata_quiet: assert property (
        !$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside the answer cycle");
    chk_unused_zero: assert property (
        rd && (addr == `AIGC_OFS_CELL_FILL || addr == `AIGC_OFS_OAM_CONTROL)
        |=> rdata[15:8] == 8'h00)
        else $error("unused register bits read nonzero");
    chk_unmapped_zero: assert property (
        rd && addr == 18'h0_0020 |=> rdata == 16'h0000)
        else $error("unmapped read returned data");
    chk_global_fields: assert property (
        wr && addr == `AIGC_OFS_GLOBAL_CONFIG && !wdata[12] && !$past(wr && wdata[12])
        ##1 !(wr && addr == `AIGC_OFS_GLOBAL_CONFIG)
        |=> cellbus_tx_enable == $past(wdata[11], 2) && hec_forum == $past(wdata[14], 2)
        && dummy_rts == $past(wdata[8:5], 2))
        else $error("global config fields not reflected");
    chk_pointer_parity: assert property (
        !$past(rst) |-> sdt_pointer_out[6:0] == $past(sdt_pointer)
        && (sdt_pointer_out[7] == 1'b0 || sdt_pointer_out[7] == ^$past(sdt_pointer)))
        else $error("pointer octet or parity bit wrong");
    chk_power_latch: assert property (
        !recovery_run && !$past(rst) |=> !recovery_run)
        else $error("clock recovery restarted without hardware reset");
    chk_fill_follow: assert property (
        wr && addr == `AIGC_OFS_CELL_FILL ##1 !wr |=> fill_octet == $past(wdata[7:0], 2))
        else $error("fill octet not taken from write");
    chk_soft_reset: assert property (
        wr && addr == `AIGC_OFS_GLOBAL_CONFIG && wdata[12] ##1 (!wr) [*4]
        |-> fill_octet == 8'h00 && emergency_byte == 8'hff && !cellbus_tx_enable)
        else $error("soft reset left settings behind");
endmodule

bind aigc_top aigc_top_props u_props (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sdt_pointer(sdt_pointer), .recovery_run(recovery_run),
    .hec_forum(hec_forum), .cellbus_tx_enable(cellbus_tx_enable), .dummy_rts(dummy_rts),
    .emergency_byte(emergency_byte), .sdt_pointer_out(sdt_pointer_out),
    .fill_octet(fill_octet)
);

// ===== verif/aigc_host.sv
`timescale 1ns/1ns
`include "aigc_defs.vh"
module aigc_host (
    // Clock and read data
    input wire ref_clk,
    input wire [15:0] rdata,
    // Bus requests
    output reg [`AIGC_ADDR_W-1:0] addr,
    output reg [15:0] wdata,
    output reg wr,
    output reg rd
);
    initial begin
        addr = 18'h0_0000;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Each cycle drives every signal once, so calls may follow back to back.
    task cyc(input logic w, input logic r, input logic [17:0] a, input logic [15:0] x);
        begin
            wr <= w;
            rd <= r;
            addr <= a;
            wdata <= x;
            @(posedge ref_clk);
        end
    endtask

    task write_reg(input logic [17:0] a, input logic [15:0] x);
        cyc(1'b1, 1'b0, a, x);
    endtask

    // Data are taken at the closing edge of the cycle after the strobe.
    task read_reg(input logic [17:0] a, output logic [15:0] x);
        begin
            cyc(1'b0, 1'b1, a, 16'h0000);
            cyc(1'b0, 1'b0, a, 16'h0000);
            x = rdata;
        end
    endtask

    task idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, addr, wdata);
    endtask
endmodule

// ===== verif/test_atm_interworking_global_config.sv
`timescale 1ns/1ns
`include "aigc_defs.vh"
module test_atm_interworking_global_config;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] rx_hdr_oct1 = 8'h00;
    reg [7:0] rx_hdr_oct4 = 8'h00;
    reg [4:0] cell_vci_low = 5'h00;
    reg [6:0] sdt_pointer = 7'h00;
    wire [`AIGC_ADDR_W-1:0] addr;
    wire [15:0] wdata, rdata;
    wire wr, rd, recovery_run, hec_forum, cellbus_tx_enable, cellbus_rx_enable;
    wire recovery_if_enable, ovf_count_enable, parity_expect_inverted, timer_group1_enable;
    wire oam_monitor_run, oam_dest_read, cpu_ram_exclusive, irq_queue_head_only;
    wire rx_idle_match, serial_transparent, down_transparent, vci_loop_accept;
    wire [3:0] dummy_rts, delin_alpha, delin_delta;
    wire [7:0] emergency_byte, sdt_pointer_out, hec_coset, tx_idle_oct1, tx_idle_oct4;
    wire [7:0] tx_idle_payload, fill_octet;
    wire [7:0] oam_cnt_en, hec_discard, udf_hec_flag, up_transparent, up_filter_en;
    int n_errors = 0;
    int tests_run = 0;
    int seed = 89223;
    int i, k;
    logic [15:0] d, e, v, g;

    always #20 ref_clk = ~ref_clk;

    aigc_top #(.PORTS(8)) dut (.*);
    aigc_host host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rst_val(input int n);
        case (n)
            4, 5: rst_val = 16'hffff;
            6: rst_val = 16'h7655;
            7: rst_val = 16'h0101;
            8: rst_val = 16'h016a;
            default: rst_val = 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] msk(input int n);
        case (n)
            1: msk = 16'h0007;
            2: msk = 16'h003f;
            9: msk = 16'h01ff;
            10: msk = 16'h00ff;
            default: msk = 16'hffff;
        endcase
    endfunction

    task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        begin
            tests_run++;
            if (g !== x) begin
                n_errors++;
                $display("wrong value %s expected %h seen %h", nm, x, g);
            end
        end
    endtask

    task put(input logic [17:0] a, input logic [15:0] x);
        begin
            host.write_reg(a, x);
            host.idle(2);
        end
    endtask

    task sweep;
        for (i = 0; i < 11; i++) begin
            host.read_reg(18'(8 + i), v);
            chk("reset value", rst_val(i), v);
        end
    endtask

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        sweep();
        // Read straight after the write, with no gap.
        for (k = 0; k < 33; k++) begin
            d = $random(seed);
            if (k % 11 == 0) d = d & 16'h6fff;
            host.write_reg(18'(8 + k % 11), d);
            host.read_reg(18'(8 + k % 11), v);
            e = d & msk(k % 11);
            if (k % 11 == 1 && !d[0]) e[1] = 1'b0;
            chk("round trip", e, v);
        end
        host.write_reg(18'h0_0020, 16'hffff);
        host.read_reg(18'h0_0020, v);
        chk("unmapped", 16'h0000, v);
        for (k = 0; k < 4; k++) begin
            d = $random(seed) & 16'h6fff;
            put(`AIGC_OFS_GLOBAL_CONFIG, d);
            v = {6'h00, hec_forum, cellbus_tx_enable, cellbus_rx_enable, recovery_if_enable,
                ovf_count_enable, parity_expect_inverted, dummy_rts};
            chk("global bits", {6'h00, d[14], d[11:9], d[2], d[0], d[8:5]}, v);
        end
        e = $random(seed);
        d = $random(seed);
        host.write_reg(`AIGC_OFS_PATTERNS_HI, e);
        host.write_reg(`AIGC_OFS_PATTERNS_LO, d);
        for (k = 0; k < 4; k++) begin
            put(`AIGC_OFS_GLOBAL_CONFIG, 16'(k << 3));
            v = k > 1 ? e : d;
            chk("emergency", k % 2 ? v[15:8] : v[7:0], {8'h00, emergency_byte});
        end
        for (k = 0; k < 8; k++) begin
            if (k % 4 == 0) put(`AIGC_OFS_GLOBAL_CONFIG, 16'(k / 2));
            sdt_pointer <= 7'($random(seed));
            host.idle(2);
            e = {8'h00, k > 3 && ^sdt_pointer, sdt_pointer};
            chk("pointer", e, {8'h00, sdt_pointer_out});
        end
        d = $random(seed);
        host.write_reg(`AIGC_OFS_CELL_DELIN, d);
        host.write_reg(`AIGC_OFS_TX_IDLE, d);
        put(`AIGC_OFS_CELL_FILL, d);
        chk("delineation", d, {delin_alpha, delin_delta, hec_coset});
        chk("tx header", {d[15:12], 8'h00, d[11:8]}, {tx_idle_oct1, tx_idle_oct4});
        chk("tx payload", {8'h00, d[7:0]}, {8'h00, tx_idle_payload});
        chk("fill", {8'h00, d[7:0]}, {8'h00, fill_octet});
        put(`AIGC_OFS_RX_IDLE, {d[15:8], 8'h00});
        rx_hdr_oct1 <= {d[15:12], 4'h0};
        rx_hdr_oct4 <= {4'h0, d[11:8]};
        host.idle(2);
        chk("idle match", 16'h0001, {15'h0000, rx_idle_match});
        rx_hdr_oct1 <= {~d[15], d[14:12], 4'h0};
        host.idle(2);
        chk("idle miss", 16'h0000, {15'h0000, rx_idle_match});
        put(`AIGC_OFS_RX_IDLE, {d[15:8], 8'h80});
        chk("idle masked", 16'h0001, {15'h0000, rx_idle_match});
        put(`AIGC_OFS_LOOPBACK, {7'h00, d[8], 1'b0, d[6], 1'b1, d[4:0]});
        cell_vci_low <= d[4:0];
        host.idle(2);
        v = {14'h0000, serial_transparent, down_transparent};
        chk("loop flags", {14'h0000, d[8], d[6]}, v);
        chk("vci hit", 16'h0001, {15'h0000, vci_loop_accept});
        cell_vci_low <= ~d[4:0];
        host.idle(2);
        chk("vci miss", 16'h0000, {15'h0000, vci_loop_accept});
        put(`AIGC_OFS_LOOPBACK, 16'h0000);
        chk("vci open", 16'h0001, {15'h0000, vci_loop_accept});
        for (k = 0; k < 2; k++) begin
            put(`AIGC_OFS_OAM_CONTROL, k ? 16'h0000 : 16'h0007);
            v = {11'h000, timer_group1_enable, oam_monitor_run, oam_dest_read,
                cpu_ram_exclusive, irq_queue_head_only};
            chk("oam mode", k ? 16'h0002 : 16'h001d, v);
        end
        d = $random(seed);
        e = $random(seed);
        host.write_reg(`AIGC_OFS_PORT_MODE, d);
        host.write_reg(`AIGC_OFS_OAM_CNT_CELL, e);
        host.write_reg(`AIGC_OFS_OAM_CNT_ADAPT, ~e);
        host.write_reg(`AIGC_OFS_LOOPBACK, {8'h00, e[0], 1'b0, e[1], 5'h00});
        put(`AIGC_OFS_GLOBAL_CONFIG, 16'h2000);
        for (k = 0; k < 8; k++) begin
            v = {11'h000, d[k] ? k < 6 && e[k] : ~e[k], ~d[k] | ~d[8 + k], d[k] & d[8 + k],
                ~d[k] & e[0], ~d[k] & d[8 + k] & e[1]};
            g = {11'h000, oam_cnt_en[k], hec_discard[k], udf_hec_flag[k], up_transparent[k],
                up_filter_en[k]};
            chk("lane", v, g);
        end
        put(`AIGC_OFS_GLOBAL_CONFIG, 16'h1000);
        sweep();
        put(`AIGC_OFS_GLOBAL_CONFIG, 16'h8000);
        chk("power down", 16'h0000, {15'h0000, recovery_run});
        put(`AIGC_OFS_GLOBAL_CONFIG, 16'h1000);
        host.idle(2);
        chk("still down", 16'h0000, {15'h0000, recovery_run});
        rst <= 1'b1;
        host.idle(2);
        rst <= 1'b0;
        host.idle(2);
        chk("power back", 16'h0001, {15'h0000, recovery_run});
        sweep();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end
endmodule
